// >>> common/fpp_map.svh
// register map, field positions and reset values of the four-pin port
`ifndef FPP_MAP_SVH
`define FPP_MAP_SVH
`define FPP_OFF_PIN   5'h00
`define FPP_OFF_LAT   5'h04
`define FPP_OFF_DIR   5'h08
`define FPP_OFF_DATA  5'h0C
`define FPP_OFF_CFG   5'h10
`define FPP_B_INFL    7
`define FPP_B_OUTF    6
`define FPP_B_OVR     5
`define FPP_B_SEL     4
`define FPP_B_IRQ     4
`define FPP_RST_DIR   3'h7
`define FPP_RST_ANA   3'h7
`define FPP_RST_LAT   3'h0
`define FPP_RST_WAIT  1'b1
`endif

// >>> common/fpp_pkg.sv
// types shared by the four-pin port
package fpp_pkg;
  typedef enum logic [2:0] {
    FPP_IDLE = 3'b001,
    FPP_WR   = 3'b010,
    FPP_RD   = 3'b100
  } fpp_slv_t;

  typedef struct packed {
    logic inFull;
    logic outFull;
    logic ovr;
    logic sel;
  } fpp_flags_t;

  typedef struct packed {
    logic       mcCfg;
    logic       pin3;
    logic [7:0] data;
    logic [2:0] pins;
  } fpp_inputs_t;
endpackage

// >>> core/fpp_port.sv
// four-pin port with direction, latch, pin read and slave-port flags
//
// Operation
// - direction bit 1 floats a pin; bit 0 drives the latch value.
// - a pin selected as analog input reads back as 0.
// - direction bits drive pins even in analog mode; software keeps them inputs.
// - after reset the three pins are selected as analog inputs.
// - latch register reads back the latch, not the pin levels.
// - with master clear off, pin 3 is input only, read at bit 3.
// - with master clear on, pin 3 is the master clear input.
// - small variant: only the input-only pin 3 exists.
// - direction bit 7 reads 1 while a received word is unread.
// - direction bit 6 reads 1 until the written word is read externally.
// - bit 5 sets on write into an unread word; software clears it.
// - direction bit 4 selects slave port mode.
// - direction bit 3 always reads 0.
// - in slave mode pin 0 is read strobe, pin 1 write strobe.
// - output drives the latch whether or not analog input is on.
// - unused pin-read and latch bits read 0.
// - in slave mode pin 2 is the chip select.
// - external write ends on strobe release, sets input-full and irq flag.
// - external read starts on select and strobe low, clears output-full.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fpp_map.svh"

module fpp_port #(
  parameter bit SMALL_PKG = 1'b0
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // port pins
  input  wire logic [2:0]  pinIn,
  output logic      [2:0]  pinOut,
  output logic      [2:0]  pinOe,
  input  wire logic        inputOnlyPin3,
  input  wire logic        masterClearCfg,
  output logic             masterClearReq,
  // slave port data and flag
  input  wire logic [7:0]  slvDataIn,
  output logic      [7:0]  slvDataOut,
  output logic             slvDataOe,
  output logic             slavePortIrqFlag
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  fpp_pkg::fpp_inputs_t syncA;
  fpp_pkg::fpp_inputs_t syncB;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {masterClearCfg, inputOnlyPin3, slvDataIn, pinIn};
      syncB <= syncA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  fpp_pkg::fpp_slv_t   slv_reg,   slv_next;
  fpp_pkg::fpp_flags_t flg_reg,   flg_next;
  logic [2:0]  dir_reg,   dir_next;
  logic [2:0]  lat_reg,   lat_next;
  logic [2:0]  ana_reg,   ana_next;
  logic        irq_reg,   irq_next;
  logic [7:0]  inW_reg,   inW_next;
  logic [7:0]  outW_reg,  outW_next;
  logic        oe_reg,    oe_next;
  logic [2:0]  pOe_reg,   pOe_next;
  logic        mcr_reg,   mcr_next;
  logic        wait_reg,  wait_next;
  logic [31:0] rd_reg,    rd_next;

  logic       portEn;
  logic       slvOn;
  logic       rdAct;
  logic       wrAct;
  logic       acc;
  logic       wrEnd;
  logic       p3Bit;
  logic [3:0] pinRead;

  assign portEn  = !SMALL_PKG;
  assign slvOn   = portEn && flg_reg.sel && (&dir_reg);
  assign rdAct   = slvOn && !syncB.pins[0] && !syncB.pins[2];
  assign wrAct   = slvOn && !syncB.pins[1] && !syncB.pins[2];
  assign acc     = (read || write) && !wait_reg;
  assign wrEnd   = (slv_reg == fpp_pkg::FPP_WR) && !wrAct;
  assign p3Bit   = !syncB.mcCfg && syncB.pin3;
  assign pinRead = {p3Bit, syncB.pins & ~ana_reg & {3{portEn}}};

  // register read view; upper bits always zero
  function automatic logic [31:0] regView(input logic [4:0] a);
    regView = '0;
    case (a)
      `FPP_OFF_PIN:  regView[3:0] = pinRead;
      `FPP_OFF_LAT:  regView[2:0] = lat_reg;
      `FPP_OFF_DIR:  regView[7:0] = {flg_reg, 1'b0, dir_reg};
      `FPP_OFF_DATA: regView[7:0] = inW_reg;
      `FPP_OFF_CFG:  regView[7:0] = {3'h0, irq_reg, 1'b0, ana_reg};
      default:       regView = '0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    slv_next  = slv_reg;
    flg_next  = flg_reg;
    dir_next  = dir_reg;
    lat_next  = lat_reg;
    ana_next  = ana_reg;
    irq_next  = irq_reg;
    inW_next  = inW_reg;
    outW_next = outW_reg;
    rd_next   = rd_reg;
    // one wait cycle per access, then a one-cycle answer
    wait_next = !((read || write) && wait_reg);
    if (read && wait_reg) begin
      rd_next = regView(address);
    end
    // software effects first so that hardware sets win
    if (acc && write && byteenable[0]) begin
      case (address)
        `FPP_OFF_LAT:  lat_next = writedata[2:0];
        `FPP_OFF_DIR: begin
          dir_next     = writedata[2:0];
          flg_next.sel = writedata[`FPP_B_SEL];
          flg_next.ovr = writedata[`FPP_B_OVR];
        end
        `FPP_OFF_DATA: begin
          outW_next    = writedata[7:0];
          flg_next.outFull = (slv_reg != fpp_pkg::FPP_RD);
        end
        `FPP_OFF_CFG: begin
          ana_next = writedata[2:0];
          if (writedata[`FPP_B_IRQ]) begin
            irq_next = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (acc && read && address == `FPP_OFF_DATA) begin
      flg_next.inFull = 1'b0;
    end
    // slave port sequencing
    case (slv_reg)
      fpp_pkg::FPP_IDLE: begin
        if (wrAct) begin
          slv_next = fpp_pkg::FPP_WR;
        end else if (rdAct) begin
          slv_next         = fpp_pkg::FPP_RD;
          flg_next.outFull = 1'b0;
        end
      end
      fpp_pkg::FPP_WR: begin
        // capture only while strobes are low; the host bus may move at release
        if (wrAct) begin
          inW_next = syncB.data;
        end
        if (!wrAct) begin
          slv_next        = fpp_pkg::FPP_IDLE;
          flg_next.inFull = 1'b1;
          irq_next        = 1'b1;
          if (flg_reg.inFull) begin
            flg_next.ovr = 1'b1;
          end
        end
      end
      fpp_pkg::FPP_RD: begin
        flg_next.outFull = 1'b0;
        if (!rdAct) begin
          slv_next = fpp_pkg::FPP_IDLE;
          irq_next = 1'b1;
        end
      end
      default: slv_next = fpp_pkg::FPP_IDLE;
    endcase
    oe_next  = (slv_next == fpp_pkg::FPP_RD);
    // direction and the package variant steer the drivers, analog select does not
    pOe_next = ~dir_next & {3{portEn}};
    mcr_next = syncB.mcCfg && !syncB.pin3;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slv_reg  <= fpp_pkg::FPP_IDLE;
      flg_reg  <= '0;
      dir_reg  <= `FPP_RST_DIR;
      lat_reg  <= `FPP_RST_LAT;
      ana_reg  <= `FPP_RST_ANA;
      irq_reg  <= 1'b0;
      inW_reg  <= '0;
      outW_reg <= '0;
      oe_reg   <= 1'b0;
      pOe_reg  <= '0;
      mcr_reg  <= 1'b0;
      wait_reg <= `FPP_RST_WAIT;
      rd_reg   <= '0;
    end else begin
      slv_reg  <= slv_next;
      flg_reg  <= flg_next;
      dir_reg  <= dir_next;
      lat_reg  <= lat_next;
      ana_reg  <= ana_next;
      irq_reg  <= irq_next;
      inW_reg  <= inW_next;
      outW_reg <= outW_next;
      oe_reg   <= oe_next;
      pOe_reg  <= pOe_next;
      mcr_reg  <= mcr_next;
      wait_reg <= wait_next;
      rd_reg   <= rd_next;
    end
  end

  assign readdata         = rd_reg;
  assign waitrequest      = wait_reg;
  assign pinOut           = lat_reg;
  assign pinOe            = pOe_reg;
  assign masterClearReq   = mcr_reg;
  assign slvDataOut       = outW_reg;
  assign slvDataOe        = oe_reg;
  assign slavePortIrqFlag = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wrEnd;
    (slv_reg == fpp_pkg::FPP_WR) && !wrAct;
  endsequence

  sequence s_rdStart;
    (slv_reg == fpp_pkg::FPP_IDLE) && !wrAct && rdAct;
  endsequence

  a_oe_from_dir: assert property (
    ##1 pinOe == (~$past(dir_next) & {3{portEn}}))
    else $error("pin enable does not follow direction");

  a_analog_reads_zero: assert property (
    read && wait_reg && address == `FPP_OFF_PIN |=> (readdata[2:0] & ana_reg) == 3'h0)
    else $error("analog pin read as nonzero");

  a_por_analog: assert property (
    $rose(rst_n) |-> ana_reg == `FPP_RST_ANA)
    else $error("pins not analog after reset");

  a_dir_bit3_zero: assert property (
    read && wait_reg && address == `FPP_OFF_DIR |=> readdata[3] == 1'b0 && readdata[31:8] == '0)
    else $error("direction bit 3 not zero");

  a_write_sets_full: assert property (
    s_wrEnd |=> flg_reg.inFull && irq_reg && slv_reg == fpp_pkg::FPP_IDLE)
    else $error("external write end did not set flags");

  a_word_kept: assert property (
    s_wrEnd |=> inW_reg == $past(inW_reg))
    else $error("received word changed at write end");

  a_overrun_set: assert property (
    s_wrEnd ##0 flg_reg.inFull |=> flg_reg.ovr)
    else $error("overrun not flagged");

  a_read_frees_out: assert property (
    s_rdStart |=> !flg_reg.outFull && slvDataOe ##1 (!slvDataOe || !flg_reg.outFull))
    else $error("external read did not clear output-full");

  a_sw_clears_in: assert property (
    acc && read && address == `FPP_OFF_DATA && slv_reg != fpp_pkg::FPP_WR |=> !flg_reg.inFull)
    else $error("input-full not cleared by data read");

  a_master_clear_input_req: assert property (
    syncB.mcCfg && !syncB.pin3 |=> masterClearReq)
    else $error("master clear not requested");

  a_pin3_read: assert property (
    read && wait_reg && address == `FPP_OFF_PIN |=> readdata[3] == $past(p3Bit))
    else $error("pin 3 read wrong");

  a_bus_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");

endmodule

// >>> bench/fpp_board_model.sv
// board-side model: strobe pins and slave data bus of an external host
`timescale 1ns/1ps
module fpp_board_model (
  // clock
  input  wire logic       clk,
  // from port
  input  wire logic [2:0] pinOut,
  input  wire logic [2:0] pinOe,
  input  wire logic [7:0] slvDataOut,
  input  wire logic       slvDataOe,
  // to port
  output logic      [2:0] pinIn,
  output logic      [7:0] slvDataIn
);
  ////////////////////////////////////////
  logic [2:0] strb = 3'b111;
  logic [7:0] bus = 8'h00;
  // a driven pin shows the port's level, a floating one ours
  assign pinIn = (pinOe & pinOut) | (~pinOe & strb);
  assign slvDataIn = bus;
  task automatic extWrite(input logic [7:0] d);
    @(posedge clk);
    strb <= 3'b001;
    bus <= d;
    repeat (4) @(posedge clk);
    strb <= 3'b111;
    // released bus must not keep showing the word
    bus <= ~d;
    repeat (6) @(posedge clk);
  endtask
  task automatic extRead(output logic [7:0] d);
    @(posedge clk);
    strb <= 3'b010;
    do @(posedge clk); while (slvDataOe !== 1'b1);
    d = slvDataOut;
    strb <= 3'b111;
    repeat (6) @(posedge clk);
  endtask
endmodule

// >>> bench/fpp_port_tb_top.sv
// self-checking bench for the four-pin port
`timescale 1ns/1ps
`include "fpp_map.svh"
module fpp_port_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic        pin3 = 1'b1;
  logic        mcCfg = 1'b0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [2:0]  pinIn, pinOut, pinOe;
  logic [7:0]  slvDataIn, slvDataOut, rdWord;
  logic        slvDataOe, mcReq, irqFlag;
  int          err_count = 0;
  int          checks = 0;
  always #50 clk = ~clk;
  ////////////////////////////////////////
  fpp_port #(.SMALL_PKG(1'b0)) u_dut (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .inputOnlyPin3(pin3),
    .masterClearCfg(mcCfg), .masterClearReq(mcReq), .slvDataIn(slvDataIn),
    .slvDataOut(slvDataOut), .slvDataOe(slvDataOe), .slavePortIrqFlag(irqFlag));
  fpp_board_model u_board (
    .clk(clk), .pinOut(pinOut), .pinOe(pinOe), .slvDataOut(slvDataOut),
    .slvDataOe(slvDataOe), .pinIn(pinIn), .slvDataIn(slvDataIn));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    read <= ~w;
    write <= w;
    writedata <= {24'h00_0000, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk(32'(pinOe), 32'(3'b000));
    rdc(`FPP_OFF_DIR, 8'h07);
    rdc(`FPP_OFF_CFG, 8'h07);
    rdc(`FPP_OFF_PIN, 8'h08);
    wr(`FPP_OFF_LAT, 8'hFA);
    rdc(`FPP_OFF_LAT, 8'h02);
    wr(`FPP_OFF_DIR, 8'h01);
    settle();
    chk(32'(pinOe), 32'(3'b110));
    chk(32'(pinOut), 32'(3'b010));
    rdc(`FPP_OFF_PIN, 8'h08);
    wr(`FPP_OFF_CFG, 8'h00);
    settle();
    rdc(`FPP_OFF_PIN, 8'h0B);
    rdc(`FPP_OFF_LAT, 8'h02);
    rdc(5'h14, 8'h00);
    // slave mode needs all pins floated first
    wr(`FPP_OFF_DIR, 8'hDF);
    rdc(`FPP_OFF_DIR, 8'h17);
    settle();
    chk(32'(pinOe), 32'(3'b000));
    u_board.extWrite(8'h3C);
    rdc(`FPP_OFF_DIR, 8'h97);
    chk(32'(irqFlag), 32'(1'b1));
    u_board.extWrite(8'hC3);
    rdc(`FPP_OFF_DIR, 8'hB7);
    rdc(`FPP_OFF_DATA, 8'hC3);
    rdc(`FPP_OFF_DIR, 8'h37);
    wr(`FPP_OFF_DIR, 8'h17);
    rdc(`FPP_OFF_DIR, 8'h17);
    wr(`FPP_OFF_DATA, 8'hA5);
    rdc(`FPP_OFF_DIR, 8'h57);
    u_board.extRead(rdWord);
    chk(32'(rdWord), 32'(8'hA5));
    rdc(`FPP_OFF_DIR, 8'h17);
    @(posedge clk);
    mcCfg <= 1'b1;
    pin3 <= 1'b0;
    settle();
    chk(32'(mcReq), 32'(1'b1));
    rdc(`FPP_OFF_PIN, 8'h07);
    end_sim();
  end
endmodule
